// [logic/sdimd_top.sv]
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sdimd_regs.svh"
module sdimd_top #(
    parameter int unsigned reference_clock_hz = `SDIMD_REF_HZ,
    parameter int unsigned rx_word_hz         = 148500000
) (
    // Clock and reset; the clock stands in for the receive and reference clocks.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Receive data status from the SDI datapath.
    input  wire logic        rx_word_i,
    input  wire logic        rx_sav_i,
    input  wire logic        rx_good_i,
    input  wire logic        rx_sig_change_i,
    // Receiver configuration.
    output sdimd_pkg::sdimd_mode_e rx_cfg_mode_o,
    output logic             rx_cfg_strobe_o,
    // Status outputs.
    output logic             mode_locked_o,
    output sdimd_pkg::sdimd_mode_e mode_o,
    output logic             rate_integer_o,
    output logic             irq_o
);
    import sdimd_pkg::*;

    typedef struct packed {
        sdimd_state_e st;
        sdimd_mode_e  mode;
        logic [15:0]  tmr;
        logic [3:0]   good;
        logic [2:0]   en;
        logic         detect;
        sdimd_mode_e  force_mode;
        logic         cfg_stb;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_en;
        logic         rate_prev;
        logic         ack;
        logic [31:0]  rdata;
    } sdimd_s;
    sdimd_s st_ff;
    sdimd_s nxt_st;

    logic rate_int;
    logic rate_done;
    logic wb_req;
    logic [2:0] irq_set;
    sdimd_mode_e nxt_mode;
    logic found;

    // expected words per window at integer rate
    localparam int unsigned WIN_WORDS = rx_word_hz / 1000 * `SDIMD_WIN_MS;

    sdimd_rate_det #(
        .reference_clock_hz(reference_clock_hz)
    ) u_rate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .word_i   (rx_word_i),
        .expect_i (32'(WIN_WORDS)),
        .integer_o(rate_int),
        .done_o   (rate_done)
    );

    // The registered ack masks the request in its own cycle, so a held strobe is taken once.
    assign wb_req = wb_cyc_i && wb_stb_i && !st_ff.ack;

    // Next enabled mode after the current one, order SD, HD, 3G.
    always_comb begin
        nxt_mode = st_ff.mode;
        found    = 1'b0;
        case (st_ff.mode)
            SDIMD_SD: begin
                if (st_ff.en[0]) begin
                    nxt_mode = SDIMD_HD;
                    found    = 1'b1;
                end else if (st_ff.en[2]) begin
                    nxt_mode = SDIMD_3G;
                    found    = 1'b1;
                end else if (st_ff.en[1]) begin
                    nxt_mode = SDIMD_SD;
                    found    = 1'b1;
                end
            end
            SDIMD_HD: begin
                if (st_ff.en[2]) begin
                    nxt_mode = SDIMD_3G;
                    found    = 1'b1;
                end else if (st_ff.en[1]) begin
                    nxt_mode = SDIMD_SD;
                    found    = 1'b1;
                end else if (st_ff.en[0]) begin
                    nxt_mode = SDIMD_HD;
                    found    = 1'b1;
                end
            end
            default: begin
                if (st_ff.en[1]) begin
                    nxt_mode = SDIMD_SD;
                    found    = 1'b1;
                end else if (st_ff.en[0]) begin
                    nxt_mode = SDIMD_HD;
                    found    = 1'b1;
                end else if (st_ff.en[2]) begin
                    nxt_mode = SDIMD_3G;
                    found    = 1'b1;
                end
            end
        endcase
    end

    // Search machine, register bus and interrupt status in one next-state process.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cfg_stb = 1'b0;
        nxt_st.ack = wb_req;
        irq_set = 3'h0;
        if (!st_ff.detect) begin
            nxt_st.st = SDIMD_ST_LOCK;
            if (st_ff.mode != st_ff.force_mode) begin
                nxt_st.mode    = st_ff.force_mode;
                nxt_st.cfg_stb = 1'b1;
            end
        end else begin
            case (st_ff.st)
                SDIMD_ST_HUNT: begin
                    // SAV halts search
                    // A SAV seen while parked on a disabled mode is ignored, so a disabled mode never enters the trial state.
                    if (rx_sav_i && st_ff.en[st_ff.mode]) begin
                        nxt_st.st   = SDIMD_ST_TRIAL;
                        nxt_st.tmr  = 16'h0;
                        nxt_st.good = 4'h0;
                        irq_set[`SDIMD_IRQ_LOCK] = 1'b1;
                    // disabled mode left
                    // After a restart the search may begin on a mode that was disabled while locked.
                    end else if (st_ff.tmr >= `SDIMD_DWELL_CYC - 16'd1 || !st_ff.en[st_ff.mode]) begin
                        nxt_st.tmr = 16'h0;
                        if (found && nxt_mode != st_ff.mode) begin
                            nxt_st.mode    = nxt_mode;
                            nxt_st.cfg_stb = 1'b1;
                        end
                    end else begin
                        nxt_st.tmr = st_ff.tmr + 16'h1;
                    end
                end
                SDIMD_ST_TRIAL: begin
                    if (rx_good_i) begin
                        nxt_st.good = st_ff.good + 4'h1;
                    end
                    if (rx_good_i && st_ff.good >= `SDIMD_GOOD_NEEDED - 4'd1) begin
                        nxt_st.st  = SDIMD_ST_LOCK;
                        nxt_st.tmr = 16'h0;
                    end else if (st_ff.tmr >= `SDIMD_TIMEOUT_CYC - 16'd1) begin
                        nxt_st.st  = SDIMD_ST_HUNT;
                        nxt_st.tmr = 16'h0;
                        irq_set[`SDIMD_IRQ_UNLOCK] = 1'b1;
                    end else begin
                        nxt_st.tmr = st_ff.tmr + 16'h1;
                    end
                end
                SDIMD_ST_LOCK: begin
                    // Enables written while locked are only read by the next search.
                    // enables apply only after signal change
                    if (rx_sig_change_i) begin
                        nxt_st.st  = SDIMD_ST_HUNT;
                        nxt_st.tmr = 16'h0;
                        irq_set[`SDIMD_IRQ_UNLOCK] = 1'b1;
                    end
                end
                default: begin
                    nxt_st.st = SDIMD_ST_HUNT;
                end
            endcase
        end
        // A rate change is flagged only at the end of a measurement window.
        if (rate_done && st_ff.rate_prev != rate_int) begin
            irq_set[`SDIMD_IRQ_RATE] = 1'b1;
        end
        nxt_st.rate_prev = rate_int;
        // Register writes; a set in the same cycle beats a clear.
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                `SDIMD_OFF_CTRL: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.en         = wb_dat_i[`SDIMD_CTRL_EN_LSB +: 3];
                        nxt_st.detect     = wb_dat_i[`SDIMD_CTRL_DETECT_BIT];
                        nxt_st.force_mode = sdimd_mode_e'(wb_dat_i[`SDIMD_CTRL_FORCE_LSB +: 2]);
                    end
                end
                `SDIMD_OFF_IRQ_CLR: begin
                    if (wb_sel_i[0]) nxt_st.irq_stat = st_ff.irq_stat & ~wb_dat_i[2:0];
                end
                `SDIMD_OFF_IRQ_EN: begin
                    if (wb_sel_i[0]) nxt_st.irq_en = wb_dat_i[2:0];
                end
                default: begin
                end
            endcase
        end
        nxt_st.irq_stat = nxt_st.irq_stat | irq_set;
        // Register reads; unmapped reads return zero.
        nxt_st.rdata = 32'h0;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `SDIMD_OFF_CTRL: nxt_st.rdata = {24'h0, 2'h0, st_ff.force_mode, st_ff.detect, st_ff.en};
                `SDIMD_OFF_STATUS: nxt_st.rdata = {28'h0, rate_integer_o, mode_o, mode_locked_o};
                `SDIMD_OFF_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
                `SDIMD_OFF_IRQ_EN: nxt_st.rdata = {29'h0, st_ff.irq_en};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{st: SDIMD_ST_HUNT, mode: SDIMD_SD, tmr: 16'h0, good: 4'h0,
                       en: 3'h7, detect: 1'b1, force_mode: SDIMD_HD, cfg_stb: 1'b0,
                       irq_stat: 3'h0, irq_en: 3'h0, rate_prev: 1'b1, ack: 1'b0, rdata: 32'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // lock forced high when search off
    assign mode_locked_o  = !st_ff.detect || (st_ff.st != SDIMD_ST_HUNT);
    assign mode_o         = st_ff.mode;
    assign rx_cfg_mode_o  = st_ff.mode;
    assign rx_cfg_strobe_o = st_ff.cfg_stb;
    // SD has no fractional family, so it reads as integer.
    assign rate_integer_o = (st_ff.mode == SDIMD_SD) ? 1'b1 : rate_int;
    assign irq_o          = |(st_ff.irq_stat & st_ff.irq_en);
    assign wb_ack_o       = st_ff.ack;
    assign wb_dat_o       = st_ff.rdata;

    // Assertions.
    chk_forced_lock_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_ff.detect |-> mode_locked_o)
        else $error("lock low with search off");

    chk_sav_locks_search: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.detect && st_ff.st == SDIMD_ST_HUNT && rx_sav_i && st_ff.en[st_ff.mode] |=> mode_locked_o)
        else $error("SAV did not lock");

    chk_trial_unlocks: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.detect && st_ff.st == SDIMD_ST_TRIAL && st_ff.tmr == `SDIMD_TIMEOUT_CYC - 16'd1 && !rx_good_i
        && !(wb_req && wb_we_i) |=> !mode_locked_o) else $error("tentative lock outlived its timeout");

    chk_enabled_mode_only: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.detect && rx_cfg_strobe_o |-> st_ff.en[mode_o])
        else $error("disabled mode tried");

    chk_lock_holds_on: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.detect && st_ff.st == SDIMD_ST_LOCK && !rx_sig_change_i && !(wb_req && wb_we_i)
        |=> st_ff.st == SDIMD_ST_LOCK && $stable(mode_o)) else $error("lock lost");

    chk_forced_reconfig: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_ff.detect && st_ff.mode != st_ff.force_mode |=> rx_cfg_strobe_o)
        else $error("forced change not applied");

    chk_rate_output: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(rate_integer_o) && $stable(mode_o) |-> rate_done)
        else $error("rate output moved between measurements");

    chk_trial_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.detect && st_ff.st == SDIMD_ST_TRIAL |-> st_ff.tmr < `SDIMD_TIMEOUT_CYC)
        else $error("timeout overrun");

    chk_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // Bus answer lasts one cycle.
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule // sdimd_top

// [logic/sdimd_regs.svh]
`ifndef SDIMD_REGS_SVH
`define SDIMD_REGS_SVH
// Register byte offsets.
`define SDIMD_OFF_CTRL     8'h00
`define SDIMD_OFF_STATUS   8'h04
`define SDIMD_OFF_IRQ_STAT 8'h08
`define SDIMD_OFF_IRQ_CLR  8'h0C
`define SDIMD_OFF_IRQ_EN   8'h10
// Control register fields.
`define SDIMD_CTRL_EN_LSB     0
`define SDIMD_CTRL_DETECT_BIT 3
`define SDIMD_CTRL_FORCE_LSB  4
`define SDIMD_CTRL_RESET      32'h0000_0007
// Status register fields.
`define SDIMD_ST_LOCK_BIT  0
`define SDIMD_ST_MODE_LSB  1
`define SDIMD_ST_RATE_BIT  3
// Interrupt bits.
`define SDIMD_IRQ_LOCK     0
`define SDIMD_IRQ_UNLOCK   1
`define SDIMD_IRQ_RATE     2
// Timing in receive-clock cycles, and the count of good pulses needed for a full lock.
`define SDIMD_DWELL_CYC    16'd1000
`define SDIMD_TIMEOUT_CYC  16'd2000
`define SDIMD_GOOD_NEEDED  4'd4
// Rate measurement: window of the reference clock, threshold in ppm.
`define SDIMD_WIN_MS       10
`define SDIMD_REF_HZ       27000000
`define SDIMD_RATE_THR_PPM 500
`endif

// [logic/sdimd_pkg.sv]
package sdimd_pkg;
    // Mode code on the mode output and the forced-mode control field.
    // two-bit mode codes
    typedef enum logic [1:0] {
        SDIMD_HD = 2'h0,
        SDIMD_SD = 2'h1,
        SDIMD_3G = 2'h2
    } sdimd_mode_e;
    // Search state machine, one-hot.
    typedef enum logic [2:0] {
        SDIMD_ST_HUNT  = 3'h1,
        SDIMD_ST_TRIAL = 3'h2,
        SDIMD_ST_LOCK  = 3'h4
    } sdimd_state_e;
endpackage

// [logic/sdimd_rate_det.sv]
`timescale 1ns/1ps
`include "sdimd_regs.svh"
// Counts receive-clock words over a window of the reference clock.
module sdimd_rate_det #(
    parameter int unsigned reference_clock_hz = `SDIMD_REF_HZ
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Word strobe and expected integer count.
    input  wire logic        word_i,
    input  wire logic [31:0] expect_i,
    // Result.
    output logic             integer_o,
    output logic             done_o
);
    localparam int unsigned WIN_CYC = reference_clock_hz / 1000 * `SDIMD_WIN_MS;
    typedef struct packed {
        logic [31:0] win;
        logic [31:0] cnt;
        logic        integ;
        logic        done;
    } sdimd_rd_s;
    sdimd_rd_s st_ff;
    sdimd_rd_s nxt_st;
    logic [63:0] thr;

    // A fractional rate is 1000 ppm slow; the 500 ppm threshold sits midway.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        thr = 64'(expect_i) * 64'(1000000 - `SDIMD_RATE_THR_PPM) / 64'd1000000;
        if (word_i) begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
        if (st_ff.win >= 32'(WIN_CYC - 1)) begin
            nxt_st.win   = 32'h0;
            nxt_st.cnt   = 32'h0;
            nxt_st.integ = (64'(st_ff.cnt) >= thr);
            nxt_st.done  = 1'b1;
        end else begin
            nxt_st.win = st_ff.win + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{win: 32'h0, cnt: 32'h0, integ: 1'b1, done: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign integer_o = st_ff.integ;
    assign done_o    = st_ff.done;
endmodule // sdimd_rate_det

// [tb/sdimd_rx_model.sv]
`timescale 1ns/1ps
// Behavioural receiver whose SAV and good pulses come only while tuned to the mode on the wire; words run regardless.
module sdimd_rx_model (
    // Clock, reset and restart.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sync_i,
    // Tuning from the block and line conditions from the bench.
    input  wire logic [1:0] cfg_mode_i,
    input  wire logic [1:0] line_mode_i,
    input  wire logic       present_i,
    input  wire logic       good_en_i,
    input  wire logic       frac_i,
    // Receive status pulses.
    output logic            word_o,
    output logic            sav_o,
    output logic            good_o
);
    logic [15:0] settle_ff;
    logic [9:0]  word_ff;
    logic [1:0]  cfg_ff;
    logic        match;
    assign match = present_i && cfg_mode_i == line_mode_i;
    // Data only makes sense some cycles after a retune, so count from it.
    always @(posedge clk_i) begin
        cfg_ff <= cfg_mode_i;
        settle_ff <= (rst_i || sync_i || cfg_ff != cfg_mode_i) ? 16'h0000 : settle_ff + 16'h0001;
        sav_o <= match && settle_ff == 16'h0010;
        good_o <= good_en_i && match && settle_ff > 16'h0010 && settle_ff[4:0] == 5'h00;
        word_ff <= (rst_i || word_ff == 10'h3E7) ? 10'h000 : word_ff + 10'h001;
        // A fractional line loses one word in a thousand.
        word_o <= !(frac_i && word_ff == 10'h3E7);
    end
endmodule // sdimd_rx_model

// [tb/tb.sv]
`timescale 1ns/1ps
`include "sdimd_regs.svh"
// Self-checking bench for search, forced mode, rate and interrupts.
module tb;
    import sdimd_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        rx_word_i, rx_sav_i, rx_good_i, rx_sig_change_i;
    sdimd_mode_e rx_cfg_mode_o, mode_o;
    logic        rx_cfg_strobe_o, mode_locked_o, rate_integer_o, irq_o;
    logic [1:0]  line_mode, prev_mode;
    logic [2:0]  en_model;
    logic        present, good_en, frac, hunt_chk, have_prev;
    int          mismatches, cmp_count, cyc_n, strb_n, strb, n, t;
    // Short reference and word rates keep the rate window at 1000 cycles.
    sdimd_top #(.reference_clock_hz(100000), .rx_word_hz(100000)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_word_i(rx_word_i), .rx_sav_i(rx_sav_i), .rx_good_i(rx_good_i),
        .rx_sig_change_i(rx_sig_change_i), .rx_cfg_mode_o(rx_cfg_mode_o),
        .rx_cfg_strobe_o(rx_cfg_strobe_o), .mode_locked_o(mode_locked_o), .mode_o(mode_o),
        .rate_integer_o(rate_integer_o), .irq_o(irq_o));
    sdimd_rx_model rx (.clk_i(clk_i), .rst_i(rst_i), .sync_i(rx_sig_change_i),
        .cfg_mode_i(rx_cfg_mode_o), .line_mode_i(line_mode), .present_i(present),
        .good_en_i(good_en), .frac_i(frac), .word_o(rx_word_i), .sav_o(rx_sav_i), .good_o(rx_good_i));
    always #50 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One classic Wishbone cycle; read data lands in q at the ack edge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        chk(k, 2);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Full lock must survive past the trial timeout.
    task automatic wait_lock();
        int k;
        k = 0;
        repeat (5) @(posedge clk_i);
        while (mode_locked_o !== 1'b1 && k < 8000) begin
            @(posedge clk_i);
            k++;
        end
        repeat (2500) @(posedge clk_i);
        chk(mode_locked_o, 1);
    endtask
    task automatic restart();
        rx_sig_change_i <= 1'b1;
        @(posedge clk_i);
        rx_sig_change_i <= 1'b0;
        have_prev = 1'b0;
    endtask
    // Reference hunt order SD, HD, 3G over the enabled modes.
    function automatic logic [1:0] next_hunt(input logic [1:0] m);
        logic [1:0] r;
        r = m;
        repeat (3) begin
            r = (r == 2'h1) ? 2'h0 : (r == 2'h0) ? 2'h2 : 2'h1;
            if (en_model[r]) return r;
        end
        return m;
    endfunction
    // Watchdog plus a check of every retune made during a search.
    always @(posedge clk_i) begin
        cyc_n++;
        if (rx_cfg_strobe_o === 1'b1) begin
            strb_n++;
            if (hunt_chk) begin
                chk(en_model[rx_cfg_mode_o], 1);
                if (have_prev) chk(rx_cfg_mode_o, next_hunt(prev_mode));
                prev_mode = rx_cfg_mode_o;
                have_prev = 1'b1;
            end
        end
        if (cyc_n == 80000) begin
            mismatches++;
            final_report();
        end
    end
    // Main sequence.
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, rx_sig_change_i} = '0;
        {mismatches, cmp_count, cyc_n, strb_n, frac, have_prev} = '0;
        {rst_i, present, good_en, hunt_chk} = 4'hF;
        line_mode = 2'h2;
        en_model = 3'h7;
        void'($urandom(5));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `SDIMD_OFF_CTRL, 0);
        chk(q & 32'h3F, 32'h0F);
        wb(1'b0, 8'h20, 0);
        chk(q, 0);
        wb(1'b1, `SDIMD_OFF_IRQ_EN, 32'h1);
        wait_lock();
        chk(mode_o, SDIMD_3G);
        wb(1'b0, `SDIMD_OFF_STATUS, 0);
        chk(q[2:0], 3'h5);
        chk(irq_o, 1);
        wb(1'b1, `SDIMD_OFF_IRQ_CLR, 32'h1);
        wb(1'b0, `SDIMD_OFF_IRQ_STAT, 0);
        chk({q[0], irq_o}, 0);
        repeat (2500) @(posedge clk_i);
        chk(rate_integer_o, 1);
        frac <= 1'b1;
        repeat (2500) @(posedge clk_i);
        chk(rate_integer_o, 0);
        wb(1'b0, `SDIMD_OFF_IRQ_STAT, 0);
        chk(q[2], 1);
        frac <= 1'b0;
        // Dropping the locked mode's enable must not break the lock.
        en_model = 3'h3;
        wb(1'b1, `SDIMD_OFF_CTRL, 32'h0B);
        repeat (3000) @(posedge clk_i);
        chk({mode_locked_o, mode_o}, {1'b1, SDIMD_3G});
        line_mode <= 2'h1;
        restart();
        wait_lock();
        chk({mode_o, rate_integer_o}, {SDIMD_SD, 1'b1});
        repeat (3) begin
            t = $urandom % 3;
            en_model = 3'(1 << t) | 3'($urandom % 8);
            wb(1'b1, `SDIMD_OFF_CTRL, {28'h0, 1'b1, en_model});
            line_mode <= t[1:0];
            restart();
            wait_lock();
            chk(mode_o, t);
        end
        // A lone SAV gives a tentative lock that times out.
        wb(1'b1, `SDIMD_OFF_IRQ_EN, 0);
        en_model = 3'h7;
        wb(1'b1, `SDIMD_OFF_CTRL, 32'h0F);
        good_en <= 1'b0;
        line_mode <= 2'h0;
        restart();
        wb(1'b1, `SDIMD_OFF_IRQ_CLR, 32'h2);
        repeat (5) @(posedge clk_i);
        for (n = 0; mode_locked_o !== 1'b1 && n < 6000; n++) @(posedge clk_i);
        for (n = 0; mode_locked_o === 1'b1 && n < 3000; n++) @(posedge clk_i);
        chk(n >= 1990 && n <= 2010, 1);
        wb(1'b0, `SDIMD_OFF_IRQ_STAT, 0);
        chk({q[1], irq_o}, 2'h2);
        hunt_chk = 1'b0;
        present <= 1'b0;
        for (t = 0; t < 3; t++) begin
            strb = strb_n;
            wb(1'b1, `SDIMD_OFF_CTRL, 32'(t << 4) | 32'h7);
            repeat (4) @(posedge clk_i);
            chk({rx_cfg_mode_o, mode_o, mode_locked_o}, {t[1:0], t[1:0], 1'b1});
            if (t > 0) chk(strb_n - strb, 1);
        end
        final_report();
    end
endmodule // tb
